// [rtl/pbcs_map.vh]
// Register map, field positions and reset values of the PHY basic control and status registers.
`ifndef PBCS_MAP_VH
`define PBCS_MAP_VH

// ----------------------------------------------------------------------
// Management addressing
// ----------------------------------------------------------------------
`define PBCS_PHY1_ADDR 5'h01
`define PBCS_PHY2_ADDR 5'h02
`define PBCS_REG_CTRL 5'h00
`define PBCS_REG_STAT 5'h01

// ----------------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------------
`define PBCS_B_LOOPBACK 14
`define PBCS_B_FORCE100 13
`define PBCS_B_AN_EN 12
`define PBCS_B_PWRDN 11
`define PBCS_B_AN_RESTART 9
`define PBCS_B_FULLDUP 8
`define PBCS_B_XALG 5
`define PBCS_B_FORCE_ST 4
`define PBCS_B_NO_XOVER 3
`define PBCS_B_NO_FEF 2
`define PBCS_B_TX_DIS 1
`define PBCS_B_LED_DIS 0

// ----------------------------------------------------------------------
// Reset values and writable mask
// ----------------------------------------------------------------------
`define PBCS_CTRL_RESET 16'h1020
`define PBCS_CTRL_WMASK 16'h7B3F
`define PBCS_STAT_UPPER 16'h7000

// ----------------------------------------------------------------------
// Per-port switch control register indices
// ----------------------------------------------------------------------
`define PBCS_P1_CTRL_A 8'h1C
`define PBCS_P1_CTRL_B 8'h1D
`define PBCS_P1_CTRL_C 8'h1F
`define PBCS_P2_CTRL_A 8'h2C
`define PBCS_P2_CTRL_B 8'h2D
`define PBCS_P2_CTRL_C 8'h2F

`endif

// [rtl/pbcs_phy_ctrl.v]
// Control storage for one PHY, reached from the management path and the switch path.
`timescale 1ns/1ps
`default_nettype none
`include "pbcs_map.vh"

module pbcs_phy_ctrl #(
    parameter HAS_FEF = 1
) (
    input wire clk, // System clock.
    input wire resetn, // Synchronous reset, active low.
    input wire mii_we, // Management write strobe.
    input wire [15:0] mii_wdata, // Management write data.
    input wire [2:0] sw_we, // Switch write strobes for regs A, B, C.
    input wire [7:0] sw_wdata, // Switch write data.
    output reg [15:0] ctrl_q, // Control register value.
    output wire [7:0] reg_a, // Switch view of reg A.
    output wire [7:0] reg_b, // Switch view of reg B.
    output wire [7:0] reg_c // Switch view of reg C.
);
    reg [15:0] ctrl_d;
    wire [15:0] wmask;

    assign wmask = HAS_FEF ? `PBCS_CTRL_WMASK : (`PBCS_CTRL_WMASK & ~16'h0004);

    // ------------------------------------------------------------------
    // Switch register views of the shared bits
    // ------------------------------------------------------------------
    assign reg_a = {ctrl_q[`PBCS_B_AN_EN], ctrl_q[`PBCS_B_FORCE100],
                    ctrl_q[`PBCS_B_FULLDUP], 5'h00}; // [RULE_15]
    assign reg_b = {ctrl_q[`PBCS_B_LED_DIS], ctrl_q[`PBCS_B_TX_DIS],
                    ctrl_q[`PBCS_B_AN_RESTART], ctrl_q[`PBCS_B_NO_FEF],
                    ctrl_q[`PBCS_B_PWRDN], ctrl_q[`PBCS_B_NO_XOVER],
                    ctrl_q[`PBCS_B_FORCE_ST], ctrl_q[`PBCS_B_LOOPBACK]}; // [RULE_15]
    assign reg_c = {ctrl_q[`PBCS_B_XALG], 7'h00}; // [RULE_15]

    // ------------------------------------------------------------------
    // Next value: management write, then switch writes
    // ------------------------------------------------------------------
    always @* begin
        ctrl_d = ctrl_q;
        if (mii_we) begin
            ctrl_d = (mii_wdata & wmask) | (ctrl_q & ~wmask); // [RULE_18]
        end
        if (sw_we[0]) begin
            ctrl_d[`PBCS_B_AN_EN] = sw_wdata[7]; // [RULE_15]
            ctrl_d[`PBCS_B_FORCE100] = sw_wdata[6];
            ctrl_d[`PBCS_B_FULLDUP] = sw_wdata[5];
        end
        if (sw_we[1]) begin
            ctrl_d[`PBCS_B_LED_DIS] = sw_wdata[7]; // [RULE_15]
            ctrl_d[`PBCS_B_TX_DIS] = sw_wdata[6];
            ctrl_d[`PBCS_B_AN_RESTART] = sw_wdata[5];
            ctrl_d[`PBCS_B_NO_FEF] = HAS_FEF ? sw_wdata[4] : 1'b0; // [RULE_12]
            ctrl_d[`PBCS_B_PWRDN] = sw_wdata[3];
            ctrl_d[`PBCS_B_NO_XOVER] = sw_wdata[2];
            ctrl_d[`PBCS_B_FORCE_ST] = sw_wdata[1];
            ctrl_d[`PBCS_B_LOOPBACK] = sw_wdata[0];
        end
        if (sw_we[2]) begin
            ctrl_d[`PBCS_B_XALG] = sw_wdata[7]; // [RULE_15]
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            ctrl_q <= `PBCS_CTRL_RESET; // [RULE_04] [RULE_05] [RULE_09]
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
endmodule
`default_nettype wire

// [rtl/pbcs_top.v]
// PHY basic control and status registers for both PHY ports of the switch.
`timescale 1ns/1ps
`default_nettype none
`include "pbcs_map.vh"

// How it works
// [RULE_01] PHY 1 answers at management address 0x1, PHY 2 at 0x2.
// [RULE_02] Port 1 loopback: port 2 traffic wraps at port 1 PHY, back out port 2.
// [RULE_03] Port 2 loopback: port 1 traffic wraps at port 2 PHY, back out port 1.
// [RULE_04] Control bit 13 forces 100 Mbps when set, 10 Mbps when clear; resets zero.
// [RULE_05] Control bit 12 enables auto-negotiation; resets to one.
// [RULE_06] Control bit 11 powers the PHY down; resets zero.
// [RULE_07] Writing one to control bit 9 restarts auto-negotiation; the code keeps the bit and restarts only when it rises from zero.
// [RULE_08] Control bit 8 forces full duplex when set, half when clear.
// [RULE_09] Control bit 5 picks the crossover algorithm; one is the reset value.
// [RULE_10] Control bit 4 forces straight-through, transmitting on the receive pair.
// [RULE_11] Control bit 3 disables automatic crossover; resets zero.
// [RULE_12] Control bit 2 disables far-end fault detection; only port 1 has it.
// [RULE_13] Control bit 1 disables the transmitter; resets zero.
// [RULE_14] Control bit 0 disables the port LEDs; resets zero.
// [RULE_15] Every writable control bit shares storage with a per-port switch register bit.
// [RULE_16] Status bit 15 always reads zero.
// [RULE_17] Status bits 14, 13 and 12 always read one.
// [RULE_18] Control bits 15, 10, 7 and 6 read zero and ignore writes.

module pbcs_top (
    input wire clk, // System clock, 25 MHz.
    input wire resetn, // Synchronous reset, active low.
    input wire mii_req, // Management access strobe, one cycle.
    input wire mii_write, // 1 = write, 0 = read.
    input wire [4:0] phy_address, // Management PHY address.
    input wire [4:0] register_index, // Management register index.
    input wire [15:0] mii_wdata, // Management write data.
    output reg [15:0] mii_rdata_q, // Management read data.
    output reg mii_ack_q, // Access was addressed to this block, one cycle.
    input wire sw_we, // Switch register write strobe.
    input wire [7:0] sw_addr, // Switch register index.
    input wire [7:0] sw_wdata, // Switch register write data.
    output reg [7:0] sw_rdata_q, // Switch register read data.
    output reg [1:0] loopback_q, // Far-end loopback per port.
    output reg [1:0] force_100_q, // Forced 100 Mbps per port.
    output reg [1:0] autoneg_enable_q, // Auto-negotiation enable per port.
    output reg [1:0] power_down_q, // Power-down per port.
    output reg [1:0] autoneg_restart_q, // Restart pulse per port, one cycle.
    output reg [1:0] full_duplex_q, // Forced full duplex per port.
    output reg [1:0] crossover_algorithm_select_q, // Crossover algorithm per port.
    output reg [1:0] force_straight_through_q, // Forced straight-through per port.
    output reg [1:0] crossover_disable_q, // Auto crossover disabled per port.
    output reg far_end_fault_disable_q, // Far-end fault detection off, port 1.
    output reg [1:0] tx_disable_q, // Transmitter disabled per port.
    output reg [1:0] led_disable_q // LEDs disabled per port.
);
    wire [15:0] ctrl1;
    wire [15:0] ctrl2;
    wire [7:0] p1a;
    wire [7:0] p1b;
    wire [7:0] p1c;
    wire [7:0] p2a;
    wire [7:0] p2b;
    wire [7:0] p2c;
    wire sel1;
    wire sel2;
    wire hit;
    wire [2:0] swe1;
    wire [2:0] swe2;
    wire [1:0] rs_req;
    reg [1:0] rs_prev_q;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function is_known_reg;
        input [4:0] idx;
        begin
            is_known_reg = (idx == `PBCS_REG_CTRL) || (idx == `PBCS_REG_STAT);
        end
    endfunction

    assign sel1 = mii_req && (phy_address == `PBCS_PHY1_ADDR); // [RULE_01]
    assign sel2 = mii_req && (phy_address == `PBCS_PHY2_ADDR); // [RULE_01]
    assign hit = (sel1 || sel2) && is_known_reg(register_index);

    assign swe1 = {sw_we && (sw_addr == `PBCS_P1_CTRL_C),
                   sw_we && (sw_addr == `PBCS_P1_CTRL_B),
                   sw_we && (sw_addr == `PBCS_P1_CTRL_A)};
    assign swe2 = {sw_we && (sw_addr == `PBCS_P2_CTRL_C),
                   sw_we && (sw_addr == `PBCS_P2_CTRL_B),
                   sw_we && (sw_addr == `PBCS_P2_CTRL_A)};

    // ------------------------------------------------------------------
    // Per-PHY control storage
    // ------------------------------------------------------------------
    pbcs_phy_ctrl #(.HAS_FEF(1)) u_phy1 (
        .clk(clk),
        .resetn(resetn),
        .mii_we(sel1 && mii_write && (register_index == `PBCS_REG_CTRL)),
        .mii_wdata(mii_wdata),
        .sw_we(swe1),
        .sw_wdata(sw_wdata),
        .ctrl_q(ctrl1),
        .reg_a(p1a),
        .reg_b(p1b),
        .reg_c(p1c)
    );

    pbcs_phy_ctrl #(.HAS_FEF(0)) u_phy2 (
        .clk(clk),
        .resetn(resetn),
        .mii_we(sel2 && mii_write && (register_index == `PBCS_REG_CTRL)),
        .mii_wdata(mii_wdata),
        .sw_we(swe2),
        .sw_wdata(sw_wdata),
        .ctrl_q(ctrl2),
        .reg_a(p2a),
        .reg_b(p2b),
        .reg_c(p2c)
    );

    // ------------------------------------------------------------------
    // Management read path
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            mii_rdata_q <= 16'h0000;
            mii_ack_q <= 1'b0;
        end else begin
            mii_ack_q <= hit;
            if (hit && !mii_write) begin
                if (register_index == `PBCS_REG_STAT) begin
                    mii_rdata_q <= `PBCS_STAT_UPPER; // [RULE_16] [RULE_17]
                end else if (sel1) begin
                    mii_rdata_q <= ctrl1; // [RULE_18]
                end else begin
                    mii_rdata_q <= ctrl2;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Switch register read path
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            sw_rdata_q <= 8'h00;
        end else begin
            case (sw_addr)
                `PBCS_P1_CTRL_A: sw_rdata_q <= p1a; // [RULE_15]
                `PBCS_P1_CTRL_B: sw_rdata_q <= p1b;
                `PBCS_P1_CTRL_C: sw_rdata_q <= p1c;
                `PBCS_P2_CTRL_A: sw_rdata_q <= p2a;
                `PBCS_P2_CTRL_B: sw_rdata_q <= p2b;
                `PBCS_P2_CTRL_C: sw_rdata_q <= p2c;
                default: sw_rdata_q <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Control outputs to the PHYs and the datapath
    // ------------------------------------------------------------------
    assign rs_req = {ctrl2[`PBCS_B_AN_RESTART], ctrl1[`PBCS_B_AN_RESTART]};

    always @(posedge clk) begin
        if (!resetn) begin
            loopback_q <= 2'h0;
            force_100_q <= 2'h0;
            autoneg_enable_q <= 2'h3;
            power_down_q <= 2'h0;
            autoneg_restart_q <= 2'h0;
            rs_prev_q <= 2'h0;
            full_duplex_q <= 2'h0;
            crossover_algorithm_select_q <= 2'h3;
            force_straight_through_q <= 2'h0;
            crossover_disable_q <= 2'h0;
            far_end_fault_disable_q <= 1'b0;
            tx_disable_q <= 2'h0;
            led_disable_q <= 2'h0;
        end else begin
            // Bit 0 wraps at PHY 1 for port 2 traffic; bit 1 at PHY 2 for port 1.
            loopback_q <= {ctrl2[`PBCS_B_LOOPBACK],
                           ctrl1[`PBCS_B_LOOPBACK]}; // [RULE_02] [RULE_03]
            force_100_q <= {ctrl2[`PBCS_B_FORCE100], ctrl1[`PBCS_B_FORCE100]}; // [RULE_04]
            autoneg_enable_q <= {ctrl2[`PBCS_B_AN_EN], ctrl1[`PBCS_B_AN_EN]}; // [RULE_05]
            power_down_q <= {ctrl2[`PBCS_B_PWRDN], ctrl1[`PBCS_B_PWRDN]}; // [RULE_06]
            // A restart pulses once on each rise of the stored bit.
            rs_prev_q <= rs_req;
            autoneg_restart_q <= rs_req & ~rs_prev_q; // [RULE_07]
            full_duplex_q <= {ctrl2[`PBCS_B_FULLDUP], ctrl1[`PBCS_B_FULLDUP]}; // [RULE_08]
            crossover_algorithm_select_q <= {ctrl2[`PBCS_B_XALG],
                                             ctrl1[`PBCS_B_XALG]}; // [RULE_09]
            force_straight_through_q <= {ctrl2[`PBCS_B_FORCE_ST],
                                         ctrl1[`PBCS_B_FORCE_ST]}; // [RULE_10]
            crossover_disable_q <= {ctrl2[`PBCS_B_NO_XOVER], ctrl1[`PBCS_B_NO_XOVER]}; // [RULE_11]
            far_end_fault_disable_q <= ctrl1[`PBCS_B_NO_FEF]; // [RULE_12]
            tx_disable_q <= {ctrl2[`PBCS_B_TX_DIS], ctrl1[`PBCS_B_TX_DIS]}; // [RULE_13]
            led_disable_q <= {ctrl2[`PBCS_B_LED_DIS], ctrl1[`PBCS_B_LED_DIS]}; // [RULE_14]
        end
    end
endmodule
`default_nettype wire

// [verif/pbcs_top_assertions.sv]
// Concurrent checks on the ports of the PHY basic control and status block.
`timescale 1ns/1ps
`default_nettype none
module pbcs_checker (
    input wire logic clk, // System clock.
    input wire logic resetn, // Reset, active low.
    input wire logic mii_req, // Access strobe.
    input wire logic mii_write, // Write select.
    input wire logic [4:0] phy_address, // PHY address.
    input wire logic [4:0] register_index, // Register index.
    input wire logic [15:0] mii_wdata, // Write data.
    input wire logic [15:0] mii_rdata_q, // Read data.
    input wire logic mii_ack_q, // Access ack.
    input wire logic sw_we, // Switch write.
    input wire logic [7:0] sw_addr, // Switch index.
    input wire logic [7:0] sw_wdata, // Switch data.
    input wire logic [1:0] loopback_q, // Loopback.
    input wire logic [1:0] force_100_q, // Speed.
    input wire logic [1:0] autoneg_restart_q // Restart pulse.
);
    wire logic hit;
    wire logic rd;
    wire logic wr1;
    wire logic wr2;
    assign hit = mii_req && (phy_address == 5'h01 || phy_address == 5'h02)
        && register_index <= 5'h01;
    assign rd = hit && !mii_write;
    assign wr1 = hit && mii_write && phy_address == 5'h01 && register_index == 5'h00 && !sw_we;
    assign wr2 = hit && mii_write && phy_address == 5'h02 && register_index == 5'h00 && !sw_we;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ack_on_hit_a: assert property (hit |=> mii_ack_q)
        else $error("no ack after an addressed access");
    ack_on_miss_a: assert property (mii_req && !hit |=> !mii_ack_q)
        else $error("ack after an access to another address");
    status_value_a: assert property (
        rd && register_index == 5'h01 |=> mii_rdata_q == 16'h7000)
        else $error("status read gave a wrong value");
    ctrl_reserved_a: assert property (
        rd && register_index == 5'h00 |=> (mii_rdata_q & 16'h84C0) == 16'h0000)
        else $error("unsupported control bit read as one");
    fef_port2_a: assert property (
        rd && phy_address == 5'h02 && register_index == 5'h00 |=> !mii_rdata_q[2])
        else $error("port 2 far-end fault bit read as one");
    loop1_follow_a: assert property (
        wr1 |-> ##2 loopback_q[0] == $past(mii_wdata[14], 2))
        else $error("port 1 loopback does not follow the write");
    loop2_follow_a: assert property (
        wr2 |-> ##2 loopback_q[1] == $past(mii_wdata[14], 2))
        else $error("port 2 loopback does not follow the write");
    speed_follow_a: assert property (
        wr1 |-> ##2 force_100_q[0] == $past(mii_wdata[13], 2))
        else $error("port 1 speed does not follow the write");
    switch_mirror_a: assert property (
        sw_we && sw_addr == 8'h1D |-> ##2 loopback_q[0] == $past(sw_wdata[0], 2))
        else $error("switch write not seen on loopback");
    restart_pulse_a: assert property (autoneg_restart_q[0] |=> !autoneg_restart_q[0])
        else $error("restart pulse longer than one cycle");
endmodule
bind pbcs_top pbcs_checker chk (.clk(clk), .resetn(resetn), .mii_req(mii_req),
    .mii_write(mii_write), .phy_address(phy_address), .register_index(register_index),
    .mii_wdata(mii_wdata), .mii_rdata_q(mii_rdata_q), .mii_ack_q(mii_ack_q), .sw_we(sw_we),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .loopback_q(loopback_q),
    .force_100_q(force_100_q), .autoneg_restart_q(autoneg_restart_q));
`default_nettype wire

// [verif/pbcs_smc.sv]
// Station management controller model that issues management accesses.
`timescale 1ns/1ps
`default_nettype none
module pbcs_smc (
    input wire logic clk, // System clock.
    input wire logic mii_ack_q, // Ack from the device.
    output logic mii_req, // Access strobe.
    output logic mii_write, // Write select.
    output logic [4:0] phy_address, // PHY address.
    output logic [4:0] register_index, // Register index.
    output logic [15:0] mii_wdata // Write data.
);
    initial begin
        mii_req = 1'b0;
        mii_write = 1'b0;
        phy_address = 5'h00;
        register_index = 5'h00;
        mii_wdata = 16'h0000;
    end
    task automatic access(input logic w, input logic [4:0] a, input logic [4:0] r,
        input logic [15:0] d, output logic ack);
        integer i;
        ack = 1'b0;
        @(negedge clk);
        mii_req = 1'b1;
        mii_write = w;
        phy_address = a;
        register_index = r;
        mii_wdata = d;
        @(negedge clk);
        mii_req = 1'b0;
        // Released data shows the inverse so a stale value can never pass.
        mii_wdata = ~d;
        for (i = 0; i < 3; i = i + 1) begin
            if (mii_ack_q === 1'b1) ack = 1'b1;
            @(negedge clk);
        end
    endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking testbench for the PHY basic control and status registers.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, resetn, sw_we, ack, mii_req, mii_write, mii_ack_q, fef;
    logic [7:0] sw_addr, sw_wdata, sw_rdata_q;
    logic [4:0] phy_address, register_index, ph, ri;
    logic [15:0] mii_wdata, mii_rdata_q, wd, ex;
    logic [1:0] lb, f100, an, pd, fd, xa, st, xd, rs, tx, led;
    logic [41:0] rows [0:4];
    integer bad_count = 0, checked = 0, pulses = 0, k;
    pbcs_smc smc (.clk(clk), .mii_ack_q(mii_ack_q), .mii_req(mii_req), .mii_write(mii_write),
        .phy_address(phy_address), .register_index(register_index), .mii_wdata(mii_wdata));
    pbcs_top dut (.clk(clk), .resetn(resetn), .mii_req(mii_req), .mii_write(mii_write),
        .phy_address(phy_address), .register_index(register_index), .mii_wdata(mii_wdata),
        .mii_rdata_q(mii_rdata_q), .mii_ack_q(mii_ack_q), .sw_we(sw_we), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_rdata_q(sw_rdata_q), .loopback_q(lb), .force_100_q(f100),
        .autoneg_enable_q(an), .power_down_q(pd), .autoneg_restart_q(rs), .full_duplex_q(fd),
        .crossover_algorithm_select_q(xa), .force_straight_through_q(st),
        .crossover_disable_q(xd), .far_end_fault_disable_q(fef), .tx_disable_q(tx),
        .led_disable_q(led));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rs[1] === 1'b1) pulses <= pulses + 1;
    end
    function automatic logic [15:0] outs(input int p);
        outs = {5'h00, (p == 0) ? fef : 1'b0, lb[p], f100[p], an[p], pd[p], fd[p],
                xa[p], st[p], xd[p], tx[p], led[p]};
    endfunction
    function automatic logic [15:0] expo(input logic [15:0] e);
        expo = {5'h00, e[2], e[14], e[13], e[12], e[11], e[8], e[5], e[4], e[3], e[1], e[0]};
    endfunction
    task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sw_we = 1'b1;
        sw_addr = a;
        sw_wdata = d;
        @(negedge clk);
        sw_we = 1'b0;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic do_reset;
        @(negedge clk);
        resetn = 1'b0;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
    endtask
    initial begin
        resetn = 1'b0;
        sw_we = 1'b0;
        sw_addr = 8'h00;
        sw_wdata = 8'h00;
        rows[0] = {5'h01, 5'h00, 16'hFFFF, 16'h7B3F};
        rows[1] = {5'h02, 5'h00, 16'hFFFF, 16'h7B3B};
        rows[2] = {5'h01, 5'h00, 16'h0000, 16'h0000};
        rows[3] = {5'h02, 5'h00, 16'h0000, 16'h0000};
        rows[4] = {5'h01, 5'h01, 16'h0000, 16'h7000};
        do_reset();
        for (k = 0; k < 5; k = k + 1) begin
            {ph, ri, wd, ex} = rows[k];
            smc.access(1'b1, ph, ri, wd, ack);
            chk({15'h0000, ack}, 16'h0001);
            smc.access(1'b0, ph, ri, 16'h0000, ack);
            chk(mii_rdata_q, ex);
            if (ri == 5'h00) chk(outs(int'(ph) - 1), expo(ex));
            $display("row %0d done", k);
        end
        k = pulses;
        smc.access(1'b1, 5'h02, 5'h00, 16'h0200, ack);
        chk(16'(pulses - k), 16'h0001);
        $display("restart test done");
        smc.access(1'b1, 5'h03, 5'h00, 16'hFFFF, ack);
        chk({15'h0000, ack}, 16'h0000);
        smc.access(1'b0, 5'h01, 5'h00, 16'h0000, ack);
        chk(mii_rdata_q, 16'h0000);
        $display("unmapped test done");
        do_reset();
        sw_addr = 8'h1C;
        repeat (2) @(negedge clk);
        chk({8'h00, an, xa, lb, pd}, 16'h00F0);
        chk({8'h00, sw_rdata_q}, 16'h0080);
        smc.access(1'b0, 5'h01, 5'h00, 16'h0000, ack);
        chk(mii_rdata_q, 16'h1020);
        $display("reset test done");
        sw_write(8'h2D, 8'h01);
        smc.access(1'b0, 5'h02, 5'h00, 16'h0000, ack);
        chk(mii_rdata_q, 16'h5020);
        chk({14'h0000, lb}, 16'h0002);
        sw_write(8'h1D, 8'h01);
        sw_write(8'h1F, 8'h00);
        sw_write(8'h2C, 8'hE0);
        smc.access(1'b0, 5'h01, 5'h00, 16'h0000, ack);
        chk(mii_rdata_q, 16'h5000);
        smc.access(1'b0, 5'h02, 5'h00, 16'h0000, ack);
        chk(mii_rdata_q, 16'h7120);
        chk({8'h00, sw_rdata_q}, 16'h00E0);
        chk({14'h0000, lb}, 16'h0003);
        $display("switch mirror test done");
        results();
    end
endmodule
`default_nettype wire
